/* bench/mic_bus_master.sv */
// two-wire bus master model facing the monitor target
module mic_bus_master
(
   input  wire logic       core_clk,
   input  wire logic       sda,
   output logic            scl,
   output logic            pull,
   output logic            res_valid,
   output logic [7:0]      res_data
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 8;
   initial
   begin
      scl = 1'b1;
      pull = 1'b0;
      res_valid = 1'b0;
      res_data = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // start or repeated start
   // sda never moves in the edge where scl falls, so no false start or stop is seen
   task automatic start();
      tick(1);
      pull <= 1'b0;
      tick(HALF);
      scl <= 1'b1;
      tick(HALF);
      pull <= 1'b1;
      tick(HALF);
      scl <= 1'b0;
   endtask
   // scl then stands high until the next frame
   task automatic stop();
      tick(1);
      pull <= 1'b1;
      tick(HALF);
      scl <= 1'b1;
      tick(HALF);
      pull <= 1'b0;
      tick(HALF);
   endtask
   task automatic clk_bit(input logic b, output logic r);
      tick(1);
      pull <= ~b;
      tick(HALF);
      scl <= 1'b1;
      tick(HALF);
      r = sda;
      scl <= 1'b0;
   endtask
   task automatic report(input logic [7:0] v);
      res_data <= v;
      res_valid <= 1'b1;
      tick(1);
      res_valid <= 1'b0;
   endtask
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         clk_bit(d[i], r);
      clk_bit(1'b1, ack);
      report({7'h00, ack});
   endtask
   task automatic read_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         clk_bit(1'b1, r);
         d[i] = r;
      end
      clk_bit(last, r);
      report(d);
   endtask
endmodule

/* bench/monitor_i2c_read_and_control_tb.sv */
// self-checking bench for the monitor serial target
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); \
      end \
   end
module monitor_i2c_read_and_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mic_pkg::*;
   logic              core_clk = 1'b0;
   logic              rst_n;
   logic              sda;
   logic              scl;
   logic              pull;
   logic              res_valid;
   logic [7:0]        res_data;
   logic              sda_oe;
   logic              sda_out;
   mic_adc_in_type    adc;
   mic_conv_ctrl_type conv_ctrl;
   int                errors = 0;
   int                tests_run = 0;
   int                starts = 0;
   logic [7:0]        q[$];
   logic [7:0]        e;
   logic [7:0]        ctrl = 8'h0c;
   logic [11:0]       res [3];
   logic              busy [3];

   // pull-up on the wire: released means high
   assign sda = ~pull & (~sda_oe | sda_out);
   always #25 core_clk = ~core_clk;

   mic_monitor_target #(.STUCK_CYCLES(20'd200)) dut (.core_clk(core_clk), .rst_n(rst_n),
      .core_ce(1'b1), .scl_link(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .adc_in(adc), .conv_ctrl(conv_ctrl));
   mic_bus_master master (.core_clk(core_clk), .sda(sda), .scl(scl), .pull(pull),
      .res_valid(res_valid), .res_data(res_data));

   always @(posedge core_clk)
   begin
      if (conv_ctrl.start === 1'b1)
         starts++;
      if (res_valid === 1'b1)
      begin
         e = q.pop_front();
         `CHK(res_data, e)
      end
   end

   task automatic wrap_up();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] d, input logic ex);
      logic a;
      q.push_back({7'h00, ex});
      master.write_byte(d, a);
   endtask
   task automatic rd(input logic [7:0] ex, input logic last);
      logic [7:0] d;
      q.push_back(ex);
      master.read_byte(last, d);
   endtask
   task automatic set_ptr(input logic [7:0] p);
      master.start();
      wr({DEV_ADDR_DEFAULT, 1'b0}, 1'b0);
      wr(p, 1'b0);
   endtask
   function automatic logic [7:0] reg_val(input logic [2:0] k);
      if (k == 3'h6)
         return ctrl;
      if (k == 3'h7)
         return 8'h00;
      return k[0] ? {res[k[2:1]][3:0], busy[k[2:1]], 3'b000} : res[k[2:1]][11:4];
   endfunction
   function automatic int chan(input logic [7:0] d);
      return (d[6:5] == 2'h1) ? 1 : (d[6:5] == 2'h2) ? 2 : 0;
   endfunction
   task automatic write_reg(input logic [2:0] p, input logic [7:0] d);
      set_ptr({5'h00, p});
      wr(d, 1'b0);
      master.stop();
      if (p == 3'h6)
      begin
         ctrl = d & 8'hfc;
         if (d[7])
            busy[chan(d)] = 1'b1;
      end
      else if (ctrl[4] && p < 3'h6)
      begin
         if (p[0])
            res[p[2:1]][3:0] = d[7:4];
         else
            res[p[2:1]][11:4] = d;
      end
   endtask
   // command, repeated start, same address with read set
   task automatic read_seq(input logic [7:0] p, input int n);
      logic [2:0] k;
      k = p[2:0];
      set_ptr(p);
      master.start();
      wr({DEV_ADDR_DEFAULT, 1'b1}, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         rd(reg_val(k), i == n - 1);
         if (ctrl[3])
            k++;
      end
      master.stop();
   endtask
   task automatic upd(input int ch);
      logic [11:0] v;
      v = 12'($urandom);
      @(posedge core_clk);
      adc <= '{update: 3'(1 << ch), sense: v, vin: v, aux: v};
      @(posedge core_clk);
      adc.update <= 3'h0;
      if (!ctrl[4])
      begin
         res[ch] = v;
         busy[ch] = 1'b0;
      end
   endtask

   initial
   begin
      #4000000;
      errors++;
      wrap_up();
   end

   initial
   begin
      logic [7:0] d;
      d = 8'($urandom(32'h79d6cdca));
      rst_n = 1'b0;
      adc = '0;
      res = '{default: 12'h000};
      busy = '{default: 1'b0};
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      `CHK(conv_ctrl, 6'b000001)
      `CHK(sda_out, 1'b0)
      read_seq(8'h06, 1);
      for (int c = 0; c < 3; c++)
         upd(c);
      read_seq(8'h00, 8);
      read_seq(8'hfb, 2);
      master.start();
      wr({DEV_ADDR_DEFAULT, 1'b1}, 1'b0);
      rd(reg_val(3'h0), 1'b1);
      master.stop();
      write_reg(3'h6, 8'h1f);
      `CHK(conv_ctrl.halt, 1'b1)
      d = 8'($urandom);
      write_reg(3'h0, d);
      upd(0);
      read_seq(8'h00, 2);
      read_seq(8'h06, 1);
      write_reg(3'h6, 8'h0c);
      write_reg(3'h2, ~reg_val(3'h2));
      read_seq(8'h02, 1);
      for (int c = 0; c < 4; c++)
      begin
         d = {1'b1, 2'(c), 5'h0c};
         write_reg(3'h6, d);
         `CHK(conv_ctrl.chan_sel, 3'(1 << chan(d)))
         `CHK(conv_ctrl.snapshot, 1'b1)
         read_seq({5'h00, 2'(chan(d)), 1'b1}, 1);
         upd(chan(d));
         read_seq({5'h00, 2'(chan(d)), 1'b1}, 1);
      end
      `CHK(starts, 4)
      write_reg(3'h6, 8'h04);
      read_seq(8'h06, 2);
      set_ptr(8'h06);
      wr(8'h04, 1'b0);
      wr(8'h00, 1'b1);
      master.stop();
      // held scl low past the timeout: the interface drops the transfer
      set_ptr(8'h06);
      master.tick(250);
      wr(8'h00, 1'b1);
      master.stop();
      write_reg(3'h6, 8'h00);
      set_ptr(8'h06);
      master.tick(250);
      wr(8'h08, 1'b0);
      master.stop();
      ctrl = 8'h08;
      read_seq(8'h06, 1);
      wrap_up();
   end
endmodule

/* design/mic_monitor_target.sv */
// serial-bus target, register pointer, result and control registers of the monitor
// Function
// - test mode freezes converter results and lets the master write them
// - page bit set allows multi-byte sequential access; clear allows one written byte and repeats one register on reads
// - stuck-bus bit enables a timer resetting the serial interface on a hang
// - two low control bits read zero and ignore writes
// - two control bits pick the channel measured in snapshot operation
// - after read address ack send pointed register, next one on master ack with page access on
// - each master ack advances the pointer when page access is on and sends the register it then points to
// - stop ends the transfer and returns the pointer to zero
// - a command byte loads only its three low bits into the pointer
// - result registers accept writes only while test mode is set
// - snapshot measures the selected channel once, clears its busy, halts
module mic_monitor_target
#(
   parameter logic [6:0]  DEV_ADDR     = mic_pkg::DEV_ADDR_DEFAULT,
   parameter logic [1:0]  CODE_SENSE   = mic_pkg::CODE_SENSE_DEFAULT,
   parameter logic [1:0]  CODE_VIN     = mic_pkg::CODE_VIN_DEFAULT,
   parameter logic [1:0]  CODE_AUX     = mic_pkg::CODE_AUX_DEFAULT,
   parameter logic [19:0] STUCK_CYCLES = mic_pkg::STUCK_CYCLES
)
(
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   input  wire logic                       core_ce,
   input  wire logic                       scl_link,
   input  wire logic                       sda_in,
   output logic                            sda_out,
   output logic                            sda_oe,
   input  wire mic_pkg::mic_adc_in_type    adc_in,
   output mic_pkg::mic_conv_ctrl_type      conv_ctrl
);
   import mic_pkg::*;

   logic          link_tog;
   logic          link_bit;
   logic          scl_s1, scl_s2, scl_d;
   logic          sda_s1, sda_s2, sda_d;
   logic          tog_s1, tog_s2, tog_d;
   logic          start_det, stop_det, scl_fall, bit_evt;
   mic_state_type state;
   mic_kind_type  kind;
   logic [7:0]    shreg;
   logic [7:0]    tx;
   logic [2:0]    bitcnt;
   logic [2:0]    ptr;
   logic [2:0]    next_ptr;
   logic [7:0]    next_tx;
   logic          ack_send, first_data, macked;
   logic          wr_stb;
   logic [2:0]    wr_addr;
   logic [7:0]    wr_data;
   logic [7:0]    control;
   logic [7:0]    res_hi [0:2];
   logic [3:0]    res_lo [0:2];
   logic [2:0]    busy;
   logic          snap_start;
   logic [19:0]   stuck_cnt;
   logic          stuck_hit;
   logic          page_on, test_on;
   logic [11:0]   adc_val [0:2];

   function automatic logic [1:0] chan_index(input logic [1:0] code);
      if (code == CODE_VIN)
         return 2'h1;
      else if (code == CODE_AUX)
         return 2'h2;
      else
         return 2'h0;
   endfunction

   function automatic logic [11:0] result_of(input mic_adc_in_type a, input int i);
      if (i == 1)
         return a.vin;
      else if (i == 2)
         return a.aux;
      else
         return a.sense;
   endfunction

   // reserved bits and register 7 read as zero
   function automatic logic [7:0] rd_reg(input logic [2:0] p);
      if (p == REG_CONTROL)
         return control;
      else if (p > REG_CONTROL)
         return 8'h00;
      else if (!p[0])
         return res_hi[p[2:1]];
      else
         return {res_lo[p[2:1]], busy[p[2:1]], 3'h0};
   endfunction

   assign page_on = control[PAGE_ACCESS_BIT];
   assign test_on = control[TEST_MODE_BIT];
   assign sda_out = 1'b0;

   // a function result cannot be part-selected, so each channel gets a word here
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         adc_val[i] = result_of(adc_in, i);
   end

   // link side: bit sampled on the bus clock, announced by a toggle
   always_ff @(posedge scl_link or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link_tog <= 1'b0;
         link_bit <= 1'b0;
      end
      else
      begin
         link_tog <= ~link_tog;
         link_bit <= sda_in;
      end
   end

   // link_bit is stable for a whole bus half-period after the toggle lands
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // idle bus level, so no false stop follows reset
         {scl_s1, scl_s2, scl_d} <= 3'h7;
         {sda_s1, sda_s2, sda_d} <= 3'h7;
         {tog_s1, tog_s2, tog_d} <= 3'h0;
      end
      else if (core_ce)
      begin
         {scl_s1, scl_s2, scl_d} <= {scl_link, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
         {tog_s1, tog_s2, tog_d} <= {link_tog, tog_s1, tog_s2};
      end
   end

   assign start_det = scl_s2 & sda_d & ~sda_s2;
   assign stop_det  = scl_s2 & ~sda_d & sda_s2;
   assign scl_fall  = scl_d & ~scl_s2;
   assign bit_evt   = tog_s2 ^ tog_d;

   // pointer only moves when page access is on
   always_comb
   begin
      next_ptr = page_on ? 3'(ptr + 3'h1) : ptr;
      next_tx  = rd_reg((state == ST_MNEXT) ? next_ptr : ptr);
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state      <= ST_IDLE;
         kind       <= K_ADDR;
         shreg      <= 8'h00;
         tx         <= 8'h00;
         bitcnt     <= 3'h0;
         ptr        <= PTR_RESET;
         sda_oe     <= 1'b0;
         ack_send   <= 1'b0;
         first_data <= 1'b0;
         macked     <= 1'b0;
         wr_stb     <= 1'b0;
         wr_addr    <= 3'h0;
         wr_data    <= 8'h00;
      end
      else if (core_ce)
      begin
         wr_stb <= 1'b0;
         // stop or stuck bus resets pointer
         if (stop_det || stuck_hit)
         begin
            state  <= ST_IDLE;
            ptr    <= PTR_RESET;
            sda_oe <= 1'b0;
         end
         else if (start_det)
         begin
            state  <= ST_RECV;
            kind   <= K_ADDR;
            bitcnt <= 3'h0;
            sda_oe <= 1'b0;
         end
         else
         begin
            unique case (state)
               ST_IDLE:
               begin
               end
               ST_RECV:
                  if (bit_evt)
                  begin
                     shreg  <= {shreg[6:0], link_bit};
                     bitcnt <= 3'(bitcnt + 3'h1);
                     if (bitcnt == 3'h7)
                        state <= ST_DECIDE;
                  end
               ST_DECIDE:
                  if (scl_fall)
                  begin
                     unique case (kind)
                        K_ADDR:
                           // read only on own address with read bit
                           if (shreg[7:1] == DEV_ADDR ||
                               (shreg[7:1] == MASS_WRITE_ADDR && !shreg[0]))
                           begin
                              sda_oe   <= 1'b1;
                              state    <= ST_ACK;
                              ack_send <= shreg[0];
                              kind     <= K_CMD;
                           end
                           else
                              state <= ST_IDLE;
                        K_CMD:
                        begin
                           // low three bits load the pointer
                           ptr        <= shreg[2:0];
                           sda_oe     <= 1'b1;
                           state      <= ST_ACK;
                           ack_send   <= 1'b0;
                           kind       <= K_DATA;
                           first_data <= 1'b1;
                        end
                        K_DATA:
                           // further bytes refused without page access
                           if (first_data || page_on)
                           begin
                              wr_stb     <= 1'b1;
                              wr_addr    <= ptr;
                              wr_data    <= shreg;
                              ptr        <= next_ptr;
                              first_data <= 1'b0;
                              sda_oe     <= 1'b1;
                              state      <= ST_ACK;
                              ack_send   <= 1'b0;
                           end
                           else
                              state <= ST_IDLE;
                     endcase
                  end
               ST_ACK:
                  if (scl_fall)
                  begin
                     bitcnt <= 3'h0;
                     // first byte is the pointed register
                     if (ack_send)
                     begin
                        tx     <= next_tx;
                        sda_oe <= ~next_tx[7];
                        state  <= ST_SEND;
                     end
                     else
                     begin
                        sda_oe <= 1'b0;
                        state  <= ST_RECV;
                     end
                  end
               ST_SEND:
                  if (scl_fall)
                  begin
                     if (bitcnt == 3'h7)
                     begin
                        sda_oe <= 1'b0;
                        state  <= ST_MACK;
                     end
                     else
                     begin
                        bitcnt <= 3'(bitcnt + 3'h1);
                        tx     <= {tx[6:0], 1'b0};
                        sda_oe <= ~tx[6];
                     end
                  end
               ST_MACK:
                  if (bit_evt)
                  begin
                     macked <= ~link_bit;
                     state  <= ST_MNEXT;
                  end
               ST_MNEXT:
                  if (scl_fall)
                  begin
                     // master ack sends the next register, or the same one without page access
                     if (macked)
                     begin
                        ptr    <= next_ptr;
                        tx     <= next_tx;
                        sda_oe <= ~next_tx[7];
                        bitcnt <= 3'h0;
                        state  <= ST_SEND;
                     end
                     else
                        state <= ST_IDLE;
                  end
            endcase
         end
      end
   end

   // stuck timer runs while scl is held low inside a transfer
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         stuck_cnt <= 20'h00000;
      else if (core_ce)
      begin
         if (scl_s2 || state == ST_IDLE || !control[STUCK_BUS_BIT])
            stuck_cnt <= 20'h00000;
         else if (stuck_cnt != STUCK_CYCLES)
            stuck_cnt <= 20'(stuck_cnt + 20'h1);
      end
   end

   assign stuck_hit = control[STUCK_BUS_BIT] && (stuck_cnt == STUCK_CYCLES);

   // a new snapshot request wins over a completion in the same cycle
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         control    <= CONTROL_RESET;
         busy       <= 3'h0;
         snap_start <= 1'b0;
         for (int i = 0; i < 3; i++)
         begin
            res_hi[i] <= 8'h00;
            res_lo[i] <= 4'h0;
         end
      end
      else if (core_ce)
      begin
         snap_start <= 1'b0;
         // converter updates blocked in test mode
         for (int i = 0; i < 3; i++)
            if (adc_in.update[i] && !test_on)
            begin
               res_hi[i] <= adc_val[i][11:4];
               res_lo[i] <= adc_val[i][3:0];
               busy[i]   <= 1'b0;
            end
         if (wr_stb && wr_addr == REG_CONTROL)
         begin
            control <= wr_data & CONTROL_WR_MASK;
            if (wr_data[SNAPSHOT_BIT])
            begin
               busy[chan_index(wr_data[CHANNEL_HI_BIT:CHANNEL_LO_BIT])] <= 1'b1;
               snap_start <= 1'b1;
            end
         end
         // result writes only in test mode
         else if (wr_stb && wr_addr < REG_CONTROL && test_on)
         begin
            if (!wr_addr[0])
               res_hi[wr_addr[2:1]] <= wr_data;
            else
               res_lo[wr_addr[2:1]] <= wr_data[7:4];
         end
      end
   end

   assign conv_ctrl.chan_sel = 3'(3'h1 << chan_index(control[CHANNEL_HI_BIT:CHANNEL_LO_BIT]));
   assign conv_ctrl.halt     = test_on;
   assign conv_ctrl.snapshot = control[SNAPSHOT_BIT];
   assign conv_ctrl.start    = snap_start;

   AST_RSV_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
      control[1:0] == 2'h0 && rd_reg(3'h7) == 8'h00)
      else $error("reserved control bits not zero");
   AST_STOP_PTR: assert property (@(posedge core_clk) disable iff (!rst_n)
      core_ce && stop_det |=> ptr == 3'h0 && state == ST_IDLE)
      else $error("stop did not clear pointer");
   AST_TEST_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_n)
      core_ce && test_on && !wr_stb |=> $stable(res_hi[1]) && $stable(res_lo[1]))
      else $error("result changed in test mode");
   AST_NO_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
      core_ce && wr_stb && wr_addr == 3'h2 && !test_on && !adc_in.update[1]
      |=> $stable(res_hi[1]))
      else $error("result written outside test mode");
   AST_CMD_PTR: assert property (@(posedge core_clk) disable iff (!rst_n)
      core_ce && state == ST_DECIDE && kind == K_CMD && scl_fall && !stop_det && !start_det
      && !stuck_hit |=> ptr == $past(shreg[2:0]))
      else $error("command pointer load wrong");
   AST_PAGE_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
      core_ce && state == ST_MNEXT && scl_fall && macked && !page_on && !stop_det
      && !start_det && !stuck_hit |=> ptr == $past(ptr))
      else $error("pointer moved without page access");
   AST_PAGE_INC: assert property (@(posedge core_clk) disable iff (!rst_n)
      core_ce && state == ST_MNEXT && scl_fall && macked && page_on && !stop_det
      && !start_det && !stuck_hit |=> ptr == 3'($past(ptr) + 3'h1) && state == ST_SEND)
      else $error("pointer did not advance");
   AST_SEND_FIRST: assert property (@(posedge core_clk) disable iff (!rst_n)
      core_ce && state == ST_ACK && ack_send && scl_fall && !stop_det && !start_det
      && !stuck_hit |=> tx == rd_reg(ptr) && sda_oe == ~tx[7])
      else $error("first read byte wrong");
   AST_STUCK: assert property (@(posedge core_clk) disable iff (!rst_n)
      core_ce && stuck_hit |=> state == ST_IDLE && !sda_oe)
      else $error("stuck bus not reset");
   AST_SNAP_SEL: assert property (@(posedge core_clk) disable iff (!rst_n)
      $onehot(conv_ctrl.chan_sel) and (conv_ctrl.start |-> conv_ctrl.snapshot))
      else $error("snapshot channel select bad");
endmodule

/* design/mic_pkg.sv */
// constants and types for the monitor serial target and control register
package mic_pkg;
   localparam int          CORE_CLK_KHZ       = 20000;
   localparam int          STUCK_TIMEOUT_US   = 25000;
   localparam logic [19:0] STUCK_CYCLES       = 20'(STUCK_TIMEOUT_US * CORE_CLK_KHZ / 1000);
   localparam logic [6:0]  DEV_ADDR_DEFAULT   = 7'h67;
   localparam logic [6:0]  MASS_WRITE_ADDR    = 7'h66;
   localparam logic [2:0]  REG_CONTROL        = 3'h6;
   localparam logic [2:0]  PTR_RESET          = 3'h0;
   localparam logic [7:0]  CONTROL_RESET      = 8'h0c;
   localparam logic [7:0]  CONTROL_WR_MASK    = 8'hfc;
   localparam int          SNAPSHOT_BIT       = 7;
   localparam int          CHANNEL_HI_BIT     = 6;
   localparam int          CHANNEL_LO_BIT     = 5;
   localparam int          TEST_MODE_BIT      = 4;
   localparam int          PAGE_ACCESS_BIT    = 3;
   localparam int          STUCK_BUS_BIT      = 2;
   localparam logic [1:0]  CODE_SENSE_DEFAULT = 2'h0;
   localparam logic [1:0]  CODE_VIN_DEFAULT   = 2'h1;
   localparam logic [1:0]  CODE_AUX_DEFAULT   = 2'h2;

   typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} mic_kind_type;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RECV, ST_DECIDE, ST_ACK, ST_SEND, ST_MACK, ST_MNEXT
   } mic_state_type;

   typedef struct packed {
      logic [2:0]  update;
      logic [11:0] sense;
      logic [11:0] vin;
      logic [11:0] aux;
   } mic_adc_in_type;

   typedef struct packed {
      logic       halt;
      logic       snapshot;
      logic       start;
      logic [2:0] chan_sel;
   } mic_conv_ctrl_type;
endpackage
